// [core/cefr_top.sv]
// Purpose: two clear-on-read charger event flag registers with masks
// Assumes: status inputs come from logic on the same 10 MHz clock
// Notes:   read data appear one cycle after the read strobe only
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

// What this block does
// - first flag register at 0x25, resets zero
// - second flag register at 0x26, resets zero
// - reading a flag register clears its flags
// - bit 7 first: one-shot conversion complete
// - continuous mode: conversion flag stays zero
// - bit 6 first: entered input current regulation
// - bit 5 first: entered input voltage regulation
// - bit 3 first: watchdog expired rising edge
// - bit 1 first: voltage timer expired rising
// - bit 0 first: charge state field changed
// - bit 7 second: power-good toggled either way
// - bit 4 second: thermistor state field changed
// - bit 3 second: reverse mode toggled
// - bit 1 second: frequency sync status changed
// - bit 0 second: tracking state field changed
// - clear mask bit lets event pulse interrupt
// - charge state is three-bit encoded field
module cefr_top (
	// clock and reset
	input  wire logic                             clk_i,
	input  wire logic                             resetn_i,
	// register port
	input  wire logic [cefr_pkg::ADDR_W-1:0]      reg_addr_i,
	input  wire logic [cefr_pkg::DATA_W-1:0]      reg_wdata_i,
	input  wire logic                             reg_wr_i,
	input  wire logic                             reg_rd_i,
	output logic      [cefr_pkg::DATA_W-1:0]      reg_rdata_o,
	// converter events
	input  wire logic                             adc_one_shot_i,
	input  wire logic                             adc_conv_done_i,
	input  wire logic                             input_current_reg_i,
	input  wire logic                             input_voltage_reg_i,
	input  wire logic                             host_watchdog_expired_status_i,
	input  wire logic                             const_voltage_timer_expired_i,
	input  wire logic [cefr_pkg::CHARGE_W-1:0]    charge_state_i,
	// second group of status
	input  wire logic                             power_good_i,
	input  wire logic [cefr_pkg::THERM_W-1:0]     thermistor_state_field_i,
	input  wire logic                             reverse_mode_i,
	input  wire logic [cefr_pkg::SYNC_W-1:0]      switching_freq_sync_pin_i,
	input  wire logic [cefr_pkg::MPPT_W-1:0]      power_point_tracking_state_i,
	// interrupt
	output logic                                  int_pulse_o
);
	import cefr_pkg::*;

	logic [7:0] flags_first_ff;
	logic [7:0] flags_second_ff;
	logic [7:0] mask_first_ff;
	logic [7:0] mask_second_ff;
	logic [7:0] nxt_flags_first;
	logic [7:0] nxt_flags_second;
	logic [7:0] nxt_rdata;
	logic [7:0] evt_first;
	logic [7:0] evt_second;
	logic       rd_first;
	logic       rd_second;
	logic       ev_cur_limit;
	logic       ev_volt_limit;
	logic       ev_watchdog;
	logic       ev_cv_timer;
	logic       ev_charge;
	logic       ev_power_good;
	logic       ev_thermistor;
	logic       ev_reverse;
	logic       ev_freq_sync;
	logic       ev_power_point;
	cefr_charge_t charge_state;

	// address decode, used for reads and writes alike
	function automatic logic hit(input logic [ADDR_W-1:0] addr,
	                             input logic [7:0]        ofs);
		hit = (addr == ofs);
	endfunction

	assign charge_state = cefr_charge_t'(charge_state_i);
	assign rd_first     = reg_rd_i && hit(reg_addr_i, OFS_FLAGS_FIRST);
	assign rd_second    = reg_rd_i && hit(reg_addr_i, OFS_FLAGS_SECOND);

	// rising-edge detectors for level conditions
	cefr_chg_det #(.WIDTH(1), .RISE_ONLY(1'b1)) u_cur_limit (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.status_i (input_current_reg_i),
		.event_o  (ev_cur_limit)
	);
	cefr_chg_det #(.WIDTH(1), .RISE_ONLY(1'b1)) u_volt_limit (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.status_i (input_voltage_reg_i),
		.event_o  (ev_volt_limit)
	);
	cefr_chg_det #(.WIDTH(1), .RISE_ONLY(1'b1)) u_watchdog (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.status_i (host_watchdog_expired_status_i),
		.event_o  (ev_watchdog)
	);
	cefr_chg_det #(.WIDTH(1), .RISE_ONLY(1'b1)) u_cv_timer (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.status_i (const_voltage_timer_expired_i),
		.event_o  (ev_cv_timer)
	);

	// any-change detectors for fields and toggles
	cefr_chg_det #(.WIDTH(CHARGE_W), .RISE_ONLY(1'b0)) u_charge (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.status_i (charge_state),
		.event_o  (ev_charge)
	);
	cefr_chg_det #(.WIDTH(1), .RISE_ONLY(1'b0)) u_power_good (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.status_i (power_good_i),
		.event_o  (ev_power_good)
	);
	cefr_chg_det #(.WIDTH(THERM_W), .RISE_ONLY(1'b0)) u_thermistor (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.status_i (thermistor_state_field_i),
		.event_o  (ev_thermistor)
	);
	cefr_chg_det #(.WIDTH(1), .RISE_ONLY(1'b0)) u_reverse (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.status_i (reverse_mode_i),
		.event_o  (ev_reverse)
	);
	cefr_chg_det #(.WIDTH(SYNC_W), .RISE_ONLY(1'b0)) u_freq_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.status_i (switching_freq_sync_pin_i),
		.event_o  (ev_freq_sync)
	);
	cefr_chg_det #(.WIDTH(MPPT_W), .RISE_ONLY(1'b0)) u_power_point (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.status_i (power_point_tracking_state_i),
		.event_o  (ev_power_point)
	);

	// gather events into register layout, reserved bits stay zero
	always_comb begin
		evt_first                 = '0;
		evt_second                = '0;
		evt_first[B1_CONV_DONE]   = adc_conv_done_i & adc_one_shot_i;
		evt_first[B1_CUR_LIMIT]   = ev_cur_limit;
		evt_first[B1_VOLT_LIMIT]  = ev_volt_limit;
		evt_first[B1_WATCHDOG]    = ev_watchdog;
		evt_first[B1_CV_TIMER]    = ev_cv_timer;
		evt_first[B1_CHARGE]      = ev_charge;
		evt_second[B2_POWER_GOOD] = ev_power_good;
		evt_second[B2_THERMISTOR] = ev_thermistor;
		evt_second[B2_REVERSE]    = ev_reverse;
		evt_second[B2_FREQ_SYNC]  = ev_freq_sync;
		evt_second[B2_POWER_POINT] = ev_power_point;
	end

	// next flags: read clears, a new event wins over the clear
	always_comb begin
		nxt_flags_first  = flags_first_ff;
		nxt_flags_second = flags_second_ff;
		if (rd_first) begin
			nxt_flags_first = RST_FLAGS;
		end
		if (rd_second) begin
			nxt_flags_second = RST_FLAGS;
		end
		nxt_flags_first  = (nxt_flags_first | evt_first) & VALID_FIRST;
		nxt_flags_second = (nxt_flags_second | evt_second) & VALID_SECOND;
		if (!adc_one_shot_i) begin
			nxt_flags_first[B1_CONV_DONE] = 1'b0;
		end
	end

	// flag registers; writes from the port never reach them
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags_first_ff  <= RST_FLAGS;
			flags_second_ff <= RST_FLAGS;
		end else begin
			flags_first_ff  <= nxt_flags_first;
			flags_second_ff <= nxt_flags_second;
		end
	end

	// interrupt mask registers, reserved bits not writable
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mask_first_ff  <= RST_MASK;
			mask_second_ff <= RST_MASK;
		end else if (reg_wr_i) begin
			if (hit(reg_addr_i, OFS_MASK_FIRST)) begin
				mask_first_ff <= reg_wdata_i & VALID_FIRST;
			end
			if (hit(reg_addr_i, OFS_MASK_SECOND)) begin
				mask_second_ff <= reg_wdata_i & VALID_SECOND;
			end
		end
	end

	// one-cycle pulse for each cycle with an unmasked event
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			int_pulse_o <= 1'b0;
		end else begin
			int_pulse_o <= |(evt_first & ~mask_first_ff) |
			               |(evt_second & ~mask_second_ff);
		end
	end

	// read mux; unmapped addresses answer zero
	always_comb begin
		nxt_rdata = RD_IDLE;
		if (reg_rd_i) begin
			if (hit(reg_addr_i, OFS_FLAGS_FIRST)) begin
				nxt_rdata = flags_first_ff;
			end else if (hit(reg_addr_i, OFS_FLAGS_SECOND)) begin
				nxt_rdata = flags_second_ff;
			end else if (hit(reg_addr_i, OFS_MASK_FIRST)) begin
				nxt_rdata = mask_first_ff;
			end else if (hit(reg_addr_i, OFS_MASK_SECOND)) begin
				nxt_rdata = mask_second_ff;
			end else begin
				nxt_rdata = RD_IDLE;
			end
		end
	end

	// read data stand for the one cycle after the strobe
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= RD_IDLE;
		end else begin
			reg_rdata_o <= nxt_rdata;
		end
	end

	// checks on the flag behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_read_first;
		reg_rd_i && hit(reg_addr_i, OFS_FLAGS_FIRST);
	endsequence

	sequence s_read_second;
		reg_rd_i && hit(reg_addr_i, OFS_FLAGS_SECOND);
	endsequence

	sequence s_unmasked_evt;
		|(evt_first & ~mask_first_ff) || |(evt_second & ~mask_second_ff);
	endsequence

	a_first_read_data:
	assert property (s_read_first |=> reg_rdata_o == $past(flags_first_ff))
		else $error("first flag register read wrong data");

	a_second_read_data:
	assert property (s_read_second |=> reg_rdata_o == $past(flags_second_ff))
		else $error("second flag register read wrong data");

	a_read_clears_first:
	assert property (s_read_first ##0 (evt_first == '0)
	                 |=> flags_first_ff == RST_FLAGS ##1 reg_rdata_o == RD_IDLE
	                     || $past(reg_rd_i))
		else $error("read did not clear first flags");

	a_read_clears_second:
	assert property (s_read_second ##0 (evt_second == '0)
	                 |=> flags_second_ff == RST_FLAGS)
		else $error("read did not clear second flags");

	a_conv_done_set:
	assert property (adc_conv_done_i && adc_one_shot_i
	                 |=> flags_first_ff[B1_CONV_DONE])
		else $error("one-shot conversion did not set flag");

	a_conv_cont_zero:
	assert property (!adc_one_shot_i |=> !flags_first_ff[B1_CONV_DONE])
		else $error("conversion flag set in continuous mode");

	a_cur_limit_rise:
	assert property ($rose(input_current_reg_i) |=> flags_first_ff[B1_CUR_LIMIT])
		else $error("current regulation entry not flagged");

	a_volt_limit_rise:
	assert property ($rose(input_voltage_reg_i)
	                 |=> flags_first_ff[B1_VOLT_LIMIT])
		else $error("voltage regulation entry not flagged");

	a_watchdog_rise:
	assert property ($rose(host_watchdog_expired_status_i)
	                 |=> flags_first_ff[B1_WATCHDOG])
		else $error("watchdog expiry not flagged");

	a_cv_timer_rise:
	assert property ($rose(const_voltage_timer_expired_i)
	                 |=> flags_first_ff[B1_CV_TIMER])
		else $error("voltage timer expiry not flagged");

	a_charge_change:
	assert property ($changed(charge_state_i) |=> flags_first_ff[B1_CHARGE])
		else $error("charge state change not flagged");

	a_power_good_tog:
	assert property ($changed(power_good_i) |=> flags_second_ff[B2_POWER_GOOD])
		else $error("power-good toggle not flagged");

	a_thermistor_change:
	assert property ($changed(thermistor_state_field_i)
	                 |=> flags_second_ff[B2_THERMISTOR])
		else $error("thermistor change not flagged");

	a_reverse_toggle:
	assert property ($changed(reverse_mode_i) |=> flags_second_ff[B2_REVERSE])
		else $error("reverse mode toggle not flagged");

	a_freq_sync_change:
	assert property ($changed(switching_freq_sync_pin_i)
	                 |=> flags_second_ff[B2_FREQ_SYNC])
		else $error("sync status change not flagged");

	a_power_point_change:
	assert property ($changed(power_point_tracking_state_i)
	                 |=> flags_second_ff[B2_POWER_POINT])
		else $error("tracking state change not flagged");

	a_int_unmasked:
	assert property (s_unmasked_evt |=> int_pulse_o)
		else $error("unmasked event gave no interrupt pulse");

	a_int_masked_quiet:
	assert property (!(|(evt_first & ~mask_first_ff) ||
	                   |(evt_second & ~mask_second_ff)) |=> !int_pulse_o)
		else $error("interrupt pulse without unmasked event");

	a_reserved_zero:
	assert property (((flags_first_ff & ~VALID_FIRST) == '0) &&
	                 ((flags_second_ff & ~VALID_SECOND) == '0))
		else $error("reserved flag bit set");

	a_write_no_effect:
	assert property (reg_wr_i && !reg_rd_i && evt_first == '0 &&
	                 adc_one_shot_i
	                 |=> flags_first_ff == $past(flags_first_ff))
		else $error("write changed first flags");

	a_set_wins_clear:
	assert property (s_read_second ##0 evt_second[B2_POWER_GOOD]
	                 |=> flags_second_ff[B2_POWER_GOOD])
		else $error("event lost during clearing read");

endmodule

// [core/cefr_pkg.sv]
// Purpose: shared constants for the charger event flag block
// Assumes: 8-bit register port, registers at their printed offsets
// Notes:   event bit positions are shared by flag and mask registers
package cefr_pkg;

	// register port widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [7:0] OFS_FLAGS_FIRST  = 8'h25;
	localparam logic [7:0] OFS_FLAGS_SECOND = 8'h26;
	localparam logic [7:0] OFS_MASK_FIRST   = 8'h28;
	localparam logic [7:0] OFS_MASK_SECOND  = 8'h29;

	// reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_MASK  = 8'h00;
	localparam logic [7:0] RD_IDLE   = 8'h00;

	// first register bit positions
	localparam int unsigned B1_CONV_DONE   = 7;
	localparam int unsigned B1_CUR_LIMIT   = 6;
	localparam int unsigned B1_VOLT_LIMIT  = 5;
	localparam int unsigned B1_WATCHDOG    = 3;
	localparam int unsigned B1_CV_TIMER    = 1;
	localparam int unsigned B1_CHARGE      = 0;

	// second register bit positions
	localparam int unsigned B2_POWER_GOOD  = 7;
	localparam int unsigned B2_THERMISTOR  = 4;
	localparam int unsigned B2_REVERSE     = 3;
	localparam int unsigned B2_FREQ_SYNC   = 1;
	localparam int unsigned B2_POWER_POINT = 0;

	// implemented bits; all others are reserved and read zero
	localparam logic [7:0] VALID_FIRST  = 8'hEB;
	localparam logic [7:0] VALID_SECOND = 8'h9B;

	// status field widths
	localparam int unsigned CHARGE_W = 3;
	localparam int unsigned THERM_W  = 3;
	localparam int unsigned SYNC_W   = 2;
	localparam int unsigned MPPT_W   = 2;

	// charge state encoding, one code reserved
	typedef enum logic [2:0] {
		CHG_NONE     = 3'h0,
		CHG_TRICKLE  = 3'h1,
		CHG_PRE      = 3'h2,
		CHG_FAST     = 3'h3,
		CHG_TAPER    = 3'h4,
		CHG_RESERVED = 3'h5,
		CHG_TOP_OFF  = 3'h6,
		CHG_DONE     = 3'h7
	} cefr_charge_t;

endpackage

// [core/cefr_chg_det.sv]
// Purpose: change or rising-edge detector for one status field
// Assumes: the status comes from logic on the same clock
// Notes:   previous value starts at zero after reset
`timescale 1ns/1ps
module cefr_chg_det #(
	parameter int unsigned WIDTH     = 1,
	parameter bit          RISE_ONLY = 1'b0
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	// status and event
	input  wire logic [WIDTH-1:0] status_i,
	output logic                  event_o
);
	import cefr_pkg::*;

	logic [WIDTH-1:0] prev_ff;

	// remember the last sampled status
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= status_i;
		end
	end

	// rising edge of bit zero, or any change of the field
	always_comb begin
		if (RISE_ONLY) begin
			event_o = status_i[0] & ~prev_ff[0];
		end else begin
			event_o = (status_i != prev_ff);
		end
	end

endmodule

// [tb/cefr_host_model.sv]
// Purpose: host side of the register port, issues reads and writes
// Assumes: one-cycle strobes, read data valid the cycle after the strobe
// Notes:   a read is split in two halves so events can share its edge
`timescale 1ns/1ps
module cefr_host_model (
	// clock
	input  wire logic       clk_i,
	// register port
	input  wire logic [7:0] reg_rdata_i,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o
);
	// idle bus at time zero
	initial begin
		reg_addr_o  = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
	end

	// one-cycle write strobe
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_wr_o    <= 1'b1;
		@(posedge clk_i);
		reg_wr_o    <= 1'b0;
	endtask

	// raise the read strobe; returns in the launching time step
	task automatic start_read(input logic [7:0] a);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_rd_o   <= 1'b1;
	endtask

	// drop the strobe and take the data in the answer cycle
	task automatic finish_read(output logic [7:0] d);
		@(posedge clk_i);
		reg_rd_o <= 1'b0;
		@(negedge clk_i);
		d = reg_rdata_i;
	endtask
endmodule

// [tb/charger_event_flag_registers_test.sv]
// Purpose: self-checking bench for the charger event flag block
// Assumes: 10 MHz clock, status inputs change right after rising edges
// Notes:   each event is raised, then undone, to probe edge sensitivity; conversion done is pulsed in both modes
`timescale 1ns/1ps
module charger_event_flag_registers_test;
	import cefr_pkg::*;

	// clock, reset and bus
	logic       clk_i;
	logic       resetn_i;
	logic [7:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic       reg_wr_i;
	logic       reg_rd_i;
	logic [7:0] reg_rdata_o;
	logic       int_pulse_o;
	// status inputs
	logic       adc_one_shot_i;
	logic       adc_conv_done_i;
	logic       input_current_reg_i;
	logic       input_voltage_reg_i;
	logic       host_watchdog_expired_status_i;
	logic       const_voltage_timer_expired_i;
	logic [2:0] charge_state_i;
	logic       power_good_i;
	logic [2:0] thermistor_state_field_i;
	logic       reverse_mode_i;
	logic [1:0] switching_freq_sync_pin_i;
	logic [1:0] power_point_tracking_state_i;
	// bookkeeping
	int         errors;
	int         checks;
	int         pulses;
	logic [7:0] rd_val;
	logic [7:0] exp_bit [11] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h02,
		8'h01, 8'h80, 8'h10, 8'h08, 8'h02, 8'h01};

	cefr_top cefr_top_i (
		.clk_i                          (clk_i),
		.resetn_i                       (resetn_i),
		.reg_addr_i                     (reg_addr_i),
		.reg_wdata_i                    (reg_wdata_i),
		.reg_wr_i                       (reg_wr_i),
		.reg_rd_i                       (reg_rd_i),
		.reg_rdata_o                    (reg_rdata_o),
		.adc_one_shot_i                 (adc_one_shot_i),
		.adc_conv_done_i                (adc_conv_done_i),
		.input_current_reg_i            (input_current_reg_i),
		.input_voltage_reg_i            (input_voltage_reg_i),
		.host_watchdog_expired_status_i (host_watchdog_expired_status_i),
		.const_voltage_timer_expired_i  (const_voltage_timer_expired_i),
		.charge_state_i                 (charge_state_i),
		.power_good_i                   (power_good_i),
		.thermistor_state_field_i       (thermistor_state_field_i),
		.reverse_mode_i                 (reverse_mode_i),
		.switching_freq_sync_pin_i      (switching_freq_sync_pin_i),
		.power_point_tracking_state_i   (power_point_tracking_state_i),
		.int_pulse_o                    (int_pulse_o)
	);

	cefr_host_model cefr_host_model_i (
		.clk_i       (clk_i),
		.reg_rdata_i (reg_rdata_o),
		.reg_addr_o  (reg_addr_i),
		.reg_wdata_o (reg_wdata_i),
		.reg_wr_o    (reg_wr_i),
		.reg_rd_o    (reg_rd_i)
	);

	// 100 ns clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// count interrupt pulses mid-cycle, where they are settled
	always @(negedge clk_i) begin
		if (int_pulse_o === 1'b1) pulses++;
	end

	// compare and report
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
		cefr_host_model_i.start_read(a);
		cefr_host_model_i.finish_read(rd_val);
		check(rd_val, exp);
	endtask

	// verdict and end of run
	task automatic complete_run();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// raise (pass 0) or undo (pass 1) one event source; conversion done is pulsed in both passes
	task automatic do_event(input int idx, input int pass);
		logic v;
		v = (pass == 0);
		@(posedge clk_i);
		case (idx)
			0: adc_conv_done_i <= 1'b1;
			1: input_current_reg_i <= v;
			2: input_voltage_reg_i <= v;
			3: host_watchdog_expired_status_i <= v;
			4: const_voltage_timer_expired_i <= v;
			5: charge_state_i <= v ? CHG_FAST : CHG_NONE;
			6: power_good_i <= v;
			7: thermistor_state_field_i <= v ? 3'h4 : 3'h0;
			8: reverse_mode_i <= v;
			9: switching_freq_sync_pin_i <= v ? 2'h1 : 2'h0;
			default: power_point_tracking_state_i <= v ? 2'h3 : 2'h0;
		endcase
		@(posedge clk_i);
		adc_conv_done_i <= 1'b0;
	endtask

	// main sequence
	initial begin
		int         p0;
		logic [7:0] exp;
		logic [7:0] a;
		errors = 0;
		checks = 0;
		pulses = 0;
		resetn_i = 1'b0;
		adc_one_shot_i = 1'b1;
		adc_conv_done_i = 1'b0;
		input_current_reg_i = 1'b0;
		input_voltage_reg_i = 1'b0;
		host_watchdog_expired_status_i = 1'b0;
		const_voltage_timer_expired_i = 1'b0;
		charge_state_i = 3'h0;
		power_good_i = 1'b0;
		thermistor_state_field_i = 3'h0;
		reverse_mode_i = 1'b0;
		switching_freq_sync_pin_i = 2'h0;
		power_point_tracking_state_i = 2'h0;
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		// reset values, unmapped address, ignored writes
		read_check(OFS_FLAGS_FIRST, 8'h00);
		read_check(OFS_FLAGS_SECOND, 8'h00);
		read_check(8'h30, 8'h00);
		cefr_host_model_i.write_reg(OFS_FLAGS_FIRST, 8'hFF);
		cefr_host_model_i.write_reg(OFS_FLAGS_SECOND, 8'hFF);
		read_check(OFS_FLAGS_FIRST, 8'h00);
		read_check(OFS_FLAGS_SECOND, 8'h00);
		// every event source raised then undone; conversion done pulsed again in continuous mode
		for (int pass = 0; pass < 2; pass++) begin
			@(posedge clk_i);
			adc_one_shot_i <= (pass == 0);
			for (int idx = 0; idx < 11; idx++) begin
				a = (idx < 6) ? OFS_FLAGS_FIRST : OFS_FLAGS_SECOND;
				exp = (pass == 1 && idx < 5) ? 8'h00 : exp_bit[idx];
				p0 = pulses;
				do_event(idx, pass);
				repeat (3) @(posedge clk_i);
				read_check(a, exp);
				read_check(a, 8'h00);
				check(8'(pulses - p0), {7'h00, exp != 8'h00});
			end
		end
		// masked event sets its flag but gives no pulse
		cefr_host_model_i.write_reg(OFS_MASK_FIRST, 8'hFF);
		cefr_host_model_i.write_reg(OFS_MASK_SECOND, 8'hFF);
		read_check(OFS_MASK_FIRST, VALID_FIRST);
		read_check(OFS_MASK_SECOND, VALID_SECOND);
		p0 = pulses;
		@(posedge clk_i);
		charge_state_i <= CHG_TOP_OFF;
		thermistor_state_field_i <= 3'h2;
		repeat (3) @(posedge clk_i);
		read_check(OFS_FLAGS_FIRST, 8'h01);
		read_check(OFS_FLAGS_SECOND, 8'h10);
		check(8'(pulses - p0), 8'h00);
		cefr_host_model_i.write_reg(OFS_MASK_FIRST, 8'h00);
		cefr_host_model_i.write_reg(OFS_MASK_SECOND, 8'h00);
		// event on the same edge as the clearing read survives
		@(posedge clk_i);
		power_good_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		cefr_host_model_i.start_read(OFS_FLAGS_SECOND);
		power_good_i <= 1'b0;
		cefr_host_model_i.finish_read(rd_val);
		check(rd_val, 8'h80);
		repeat (3) @(posedge clk_i);
		read_check(OFS_FLAGS_SECOND, 8'h80);
		read_check(OFS_FLAGS_SECOND, 8'h00);
		complete_run();
	end

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#2000000;
		errors++;
		complete_run();
	end
endmodule
